// *** logic/ccm_iv_pkg.sv ***
// shared constants and types for the ccm initialization vector builder
`default_nettype none
package ccm_iv_pkg;

  // ----------------------------------------------------------------
  // vector layout
  // ----------------------------------------------------------------
  localparam int IV_OCTETS = 16;
  localparam int IV_BITS = 128;
  localparam int NONCE_FIRST = 1;
  localparam int NONCE_LAST = 13;
  localparam int NONCE_BITS = 104;
  localparam int PN_BITS = 48;
  localparam int FP_ID_BITS = 12;
  localparam int PSI_BITS = 20;
  localparam int LCN_BITS = 3;
  localparam int LEN_BITS = 16;

  // ----------------------------------------------------------------
  // flags byte: no associated data, 4-octet mic, 2-octet length
  // ----------------------------------------------------------------
  localparam int MIC_OCTETS = 4;
  localparam int LEN_FIELD_OCTETS = 2;
  localparam logic FLAG_RESERVED = 1'b0;
  localparam logic FLAG_ADATA = 1'b0;
  localparam logic [2:0] FLAG_MIC_CODE = 3'((MIC_OCTETS - 2) / 2);
  localparam logic [2:0] FLAG_LEN_CODE = 3'(LEN_FIELD_OCTETS - 1);
  localparam logic [7:0] NONCE_RESERVED = 8'h00;
  localparam logic [3:0] DIR_RESERVED = 4'h0;
  localparam logic [7:0] FIXED_OCTET = 8'h00;
  localparam logic [15:0] LEN_MIN = 16'h0001;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] ACCESS_ID_ADDR = 12'h004;
  localparam logic [11:0] PORT_ID_ADDR = 12'h008;
  localparam logic [11:0] CONN_ADDR = 12'h00C;
  localparam logic [11:0] PN_LO_ADDR = 12'h010;
  localparam logic [11:0] PN_HI_ADDR = 12'h014;
  localparam logic [11:0] LEN_ADDR = 12'h018;
  localparam logic [11:0] STATUS_ADDR = 12'h01C;
  localparam logic [11:0] IV_BASE_ADDR = 12'h020;
  localparam logic [11:0] IV_LAST_ADDR = 12'h02C;

  // ----------------------------------------------------------------
  // register bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_BUILD_BIT = 0;
  localparam int CTRL_OPEN_BIT = 1;
  localparam int CTRL_CLOSE_BIT = 2;
  localparam int CTRL_UPLINK_BIT = 3;
  localparam int ST_VALID_BIT = 0;
  localparam int ST_LEN_ERR_BIT = 1;
  localparam int ST_LINK_ERR_BIT = 2;
  localparam int ST_OPEN_BIT = 3;
  localparam int ST_LCN_LSB = 4;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // fields that make up one vector
  typedef struct packed {
    logic [PN_BITS-1:0] pn;
    logic [FP_ID_BITS-1:0] fp_id;
    logic [PSI_BITS-1:0] psi;
    logic [LCN_BITS-1:0] link_connection_number;
    logic uplink;
    logic [LEN_BITS-1:0] sdu_len;
  } iv_fields_type;

endpackage

`default_nettype wire

// *** logic/ccm_iv_packer.sv ***
// packs the vector fields into sixteen octets, held in a register
`timescale 1ns/1ns
`default_nettype none

module ccm_iv_packer (
  input wire logic mclk, // system clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic load, // capture the fields this cycle
  input wire ccm_iv_pkg::iv_fields_type fields, // fields of the vector
  output logic [ccm_iv_pkg::IV_BITS-1:0] iv_q, // octet 0 in the top byte
  output logic [ccm_iv_pkg::NONCE_BITS-1:0] nonce_q // octets 1 to 13
);

  // ----------------------------------------------------------------
  // octet assembly; bit 7 of each octet is its msb
  // ----------------------------------------------------------------
  wire logic [7:0] flags = {ccm_iv_pkg::FLAG_RESERVED, ccm_iv_pkg::FLAG_ADATA,
                            ccm_iv_pkg::FLAG_MIC_CODE, ccm_iv_pkg::FLAG_LEN_CODE};
  wire logic [31:0] ident = {fields.fp_id, fields.psi};
  wire logic [7:0] dir_lcn = {fields.uplink, ccm_iv_pkg::DIR_RESERVED, fields.link_connection_number};
  wire logic [ccm_iv_pkg::IV_BITS-1:0] iv_d = {
    flags,
    ccm_iv_pkg::NONCE_RESERVED,
    fields.pn,
    ident,
    dir_lcn,
    ccm_iv_pkg::FIXED_OCTET,
    fields.sdu_len
  };
  // nonce is the slice between the flags octet and the length field
  wire logic [ccm_iv_pkg::NONCE_BITS-1:0] nonce_d =
    iv_d[ccm_iv_pkg::IV_BITS-8-1 -: ccm_iv_pkg::NONCE_BITS];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      iv_q <= '0;
      nonce_q <= '0;
    end else if (load) begin
      iv_q <= iv_d;
      nonce_q <= nonce_d;
    end
  end

endmodule

`default_nettype wire

// *** logic/ccm_iv_builder.sv ***
// apb-controlled builder of the ccm initialization vector for connection links
`timescale 1ns/1ns
`default_nettype none

module ccm_iv_builder #(
  parameter int ACCESS_ID_W = 20, // width of the primary access rights identity
  parameter int CONN_W = 4 // width of the exchanged connection number
) (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error, unmapped address
  output logic [ccm_iv_pkg::IV_BITS-1:0] iv, // vector to the ccm engine
  output logic [ccm_iv_pkg::NONCE_BITS-1:0] nonce, // nonce to the ccm engine
  output logic iv_valid, // vector is current, level
  output logic iv_load // one-cycle pulse when a new vector appears
);

  // ----------------------------------------------------------------
  // build sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IDLE,
    CHECK,
    LOAD
  } build_state_type;

  // ----------------------------------------------------------------
  // byte-lane merge for apb writes
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    // lanes whose strobe is low keep the old register byte
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [ACCESS_ID_W-1:0] access_id_q;
  logic [ccm_iv_pkg::PSI_BITS-1:0] psi_q;
  logic [CONN_W-1:0] conn_q;
  logic [ccm_iv_pkg::PN_BITS-1:0] pn_q;
  logic [ccm_iv_pkg::LEN_BITS-1:0] len_q;
  logic uplink_q;
  logic open_q;
  logic [ccm_iv_pkg::LCN_BITS-1:0] lcn_q;
  logic build_req_q;
  logic valid_q;
  logic len_err_q;
  logic link_err_q;
  logic load_q;
  build_state_type state_q;
  build_state_type state_d;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // one wait state: ready rises in the second access cycle so that read
  // data can come from a flip-flop
  wire logic access = psel && penable;
  wire logic first_access = access && !pready_q;
  wire logic done = access && pready_q;
  wire logic wr_done = done && pwrite;
  wire logic sel_ctrl = (paddr == ccm_iv_pkg::CTRL_ADDR);
  wire logic sel_access_id = (paddr == ccm_iv_pkg::ACCESS_ID_ADDR);
  wire logic sel_port_id = (paddr == ccm_iv_pkg::PORT_ID_ADDR);
  wire logic sel_conn = (paddr == ccm_iv_pkg::CONN_ADDR);
  wire logic sel_pn_lo = (paddr == ccm_iv_pkg::PN_LO_ADDR);
  wire logic sel_pn_hi = (paddr == ccm_iv_pkg::PN_HI_ADDR);
  wire logic sel_len = (paddr == ccm_iv_pkg::LEN_ADDR);
  wire logic sel_status = (paddr == ccm_iv_pkg::STATUS_ADDR);
  // only aligned words decode; a misaligned address answers with an error
  wire logic sel_iv = (paddr >= ccm_iv_pkg::IV_BASE_ADDR) &&
                      (paddr <= ccm_iv_pkg::IV_LAST_ADDR) && (paddr[1:0] == 2'b00);
  wire logic mapped = sel_ctrl || sel_access_id || sel_port_id || sel_conn ||
                      sel_pn_lo || sel_pn_hi || sel_len || sel_status || sel_iv;
  wire logic [1:0] iv_word = 2'(paddr[3:2]);

  // ----------------------------------------------------------------
  // register views
  // ----------------------------------------------------------------
  wire logic [31:0] ctrl_view = {28'h000_0000, uplink_q, 3'b000};
  wire logic [31:0] access_id_view = 32'(access_id_q);
  wire logic [31:0] port_id_view = 32'(psi_q);
  wire logic [31:0] conn_view = 32'(conn_q);
  wire logic [31:0] pn_lo_view = pn_q[31:0];
  wire logic [31:0] pn_hi_view = 32'(pn_q[ccm_iv_pkg::PN_BITS-1:32]);
  wire logic [31:0] len_view = 32'(len_q);
  wire logic [31:0] status_view = (32'(lcn_q) << ccm_iv_pkg::ST_LCN_LSB) |
                                  (32'(open_q) << ccm_iv_pkg::ST_OPEN_BIT) |
                                  (32'(link_err_q) << ccm_iv_pkg::ST_LINK_ERR_BIT) |
                                  (32'(len_err_q) << ccm_iv_pkg::ST_LEN_ERR_BIT) |
                                  (32'(valid_q) << ccm_iv_pkg::ST_VALID_BIT);
  // octet 0 sits in the top byte of the first vector word
  wire logic [31:0] iv_view = iv[ccm_iv_pkg::IV_BITS-1 - 32*iv_word -: 32];

  wire logic [31:0] rd_mux = sel_ctrl ? ctrl_view :
                             sel_access_id ? access_id_view :
                             sel_port_id ? port_id_view :
                             sel_conn ? conn_view :
                             sel_pn_lo ? pn_lo_view :
                             sel_pn_hi ? pn_hi_view :
                             sel_len ? len_view :
                             sel_status ? status_view :
                             sel_iv ? iv_view : ccm_iv_pkg::WORD_ZERO;

  // ----------------------------------------------------------------
  // write data after byte strobes
  // ----------------------------------------------------------------
  localparam logic [31:0] WORD_ZERO_W = ccm_iv_pkg::WORD_ZERO;
  wire logic [31:0] ctrl_wd = merge(WORD_ZERO_W, pwdata, pstrb);
  wire logic [31:0] access_id_wd = merge(access_id_view, pwdata, pstrb);
  wire logic [31:0] port_id_wd = merge(port_id_view, pwdata, pstrb);
  wire logic [31:0] conn_wd = merge(conn_view, pwdata, pstrb);
  wire logic [31:0] pn_lo_wd = merge(pn_lo_view, pwdata, pstrb);
  wire logic [31:0] pn_hi_wd = merge(pn_hi_view, pwdata, pstrb);
  wire logic [31:0] len_wd = merge(len_view, pwdata, pstrb);
  wire logic [31:0] status_wd = merge(WORD_ZERO_W, pwdata, pstrb);


  // strobes fire only on the completing edge, where the master samples pready
  wire logic wr_ctrl = wr_done && sel_ctrl;
  wire logic wr_access_id = wr_done && sel_access_id;
  wire logic wr_port_id = wr_done && sel_port_id;
  wire logic wr_conn = wr_done && sel_conn;
  wire logic wr_pn_lo = wr_done && sel_pn_lo;
  wire logic wr_pn_hi = wr_done && sel_pn_hi;
  wire logic wr_len = wr_done && sel_len;
  wire logic build_cmd = wr_ctrl && ctrl_wd[ccm_iv_pkg::CTRL_BUILD_BIT];
  wire logic open_cmd = wr_ctrl && ctrl_wd[ccm_iv_pkg::CTRL_OPEN_BIT];
  wire logic close_cmd = wr_ctrl && ctrl_wd[ccm_iv_pkg::CTRL_CLOSE_BIT];
  wire logic wr_status = wr_done && sel_status;
  wire logic clr_len_err = wr_status && status_wd[ccm_iv_pkg::ST_LEN_ERR_BIT];
  wire logic clr_link_err = wr_status && status_wd[ccm_iv_pkg::ST_LINK_ERR_BIT];

  // link connection number is the constant low part of the exchanged number
  wire logic [ccm_iv_pkg::LCN_BITS-1:0] conn_const = conn_q[ccm_iv_pkg::LCN_BITS-1:0];

  // ----------------------------------------------------------------
  // build checks
  // ----------------------------------------------------------------
  wire logic len_ok = (len_q >= ccm_iv_pkg::LEN_MIN);
  wire logic build_ok = len_ok && open_q;
  wire logic set_len_err = (state_q == CHECK) && !len_ok;
  wire logic set_link_err = (state_q == CHECK) && !open_q;
  // the packer, the load pulse and the valid flag all key off this one decode
  wire logic load_now = (state_q == LOAD);

  // fields handed to the packer; identity is cut to its low twelve bits
  wire ccm_iv_pkg::iv_fields_type fields = '{
    pn: pn_q,
    fp_id: access_id_q[ccm_iv_pkg::FP_ID_BITS-1:0],
    psi: psi_q,
    link_connection_number: lcn_q,
    uplink: uplink_q,
    sdu_len: len_q
  };

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
      prdata_q <= ccm_iv_pkg::WORD_ZERO;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= first_access;
      // forced to zero outside a read answer so stale data never shows on the bus
      prdata_q <= (first_access && !pwrite) ? rd_mux : ccm_iv_pkg::WORD_ZERO;
      pslverr_q <= first_access && !mapped;
    end
  end

  // ----------------------------------------------------------------
  // software-written fields
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      access_id_q <= '0;
      psi_q <= '0;
      conn_q <= '0;
      pn_q <= '0;
      len_q <= '0;
      uplink_q <= 1'b0;
    end else begin
      if (wr_access_id) begin
        access_id_q <= access_id_wd[ACCESS_ID_W-1:0];
      end
      if (wr_port_id) begin
        psi_q <= port_id_wd[ccm_iv_pkg::PSI_BITS-1:0];
      end
      if (wr_conn) begin
        conn_q <= conn_wd[CONN_W-1:0];
      end
      if (wr_pn_lo) begin
        pn_q[31:0] <= pn_lo_wd;
      end
      // only the low sixteen bits of the upper word belong to the packet number
      if (wr_pn_hi) begin
        pn_q[ccm_iv_pkg::PN_BITS-1:32] <= pn_hi_wd[15:0];
      end
      if (wr_len) begin
        len_q <= len_wd[ccm_iv_pkg::LEN_BITS-1:0];
      end
      // each direction keeps its own bit, so the two vectors differ
      if (wr_ctrl) begin
        uplink_q <= ctrl_wd[ccm_iv_pkg::CTRL_UPLINK_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // link state: number is frozen at link creation
  // ----------------------------------------------------------------
  // a later change of the exchanged number, such as on handover, is ignored
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      open_q <= 1'b0;
      lcn_q <= '0;
    // close beats open when both bits arrive in one word
    end else if (close_cmd) begin
      open_q <= 1'b0;
    end else if (open_cmd && !open_q) begin
      open_q <= 1'b1;
      lcn_q <= conn_const;
    end
  end

  // ----------------------------------------------------------------
  // build sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      IDLE: begin
        if (build_req_q) state_d = CHECK;
      end
      CHECK: begin
        state_d = build_ok ? LOAD : IDLE;
      end
      LOAD: begin
        state_d = IDLE;
      end
      default: begin
        state_d = IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= IDLE;
      build_req_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // a build command during a build is held as a new request and starts another build once back in IDLE
      build_req_q <= build_cmd || (build_req_q && state_q != IDLE);
      load_q <= load_now;
    end
  end

  // ----------------------------------------------------------------
  // status flags; a set in the same cycle as a clear wins
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      valid_q <= 1'b0;
      len_err_q <= 1'b0;
      link_err_q <= 1'b0;
    end else begin
      len_err_q <= set_len_err || (len_err_q && !clr_len_err);
      link_err_q <= set_link_err || (link_err_q && !clr_link_err);
      // valid drops on a new build so software never trusts an unchecked vector
      if (load_now) begin
        valid_q <= 1'b1;
      end else if (build_cmd || close_cmd) begin
        valid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // vector register
  // ----------------------------------------------------------------
  // vector and nonce registers load from one packed word on one strobe, so the two can never disagree
  ccm_iv_packer u_packer (
    .mclk(mclk),
    .arst_n(arst_n),
    .load(load_now),
    .fields(fields),
    .iv_q(iv),
    .nonce_q(nonce)
  );

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign iv_valid = valid_q;
  assign iv_load = load_q;

endmodule

`default_nettype wire

// *** sim/ccm_iv_builder_asserts.sv ***
// port checker for the ccm vector builder, bound to its top module
`timescale 1ns/1ns
`default_nettype none

module ccm_iv_builder_asserts #(
  parameter int ACCESS_ID_W = 20, // access rights identity width
  parameter int CONN_W = 4 // connection number width
) (
  input wire logic mclk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [ccm_iv_pkg::IV_BITS-1:0] iv, // vector
  input wire logic [ccm_iv_pkg::NONCE_BITS-1:0] nonce, // nonce
  input wire logic iv_valid, // vector current
  input wire logic iv_load // new vector pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // shadow of the fields; assumes no field is rewritten mid-build
  // ----------------------------------------------------------------
  wire wr = psel && penable && pready && pwrite;
  logic [47:0] pn_q;
  logic [31:0] id_q;
  logic [19:0] ps_q;
  logic [15:0] len_q;
  logic up_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pn_q <= '0;
      id_q <= '0;
      ps_q <= '0;
      len_q <= '0;
      up_q <= 1'b0;
    end else if (wr) begin
      if (paddr == ccm_iv_pkg::PN_LO_ADDR) pn_q[31:0] <= pwdata;
      if (paddr == ccm_iv_pkg::PN_HI_ADDR) pn_q[47:32] <= pwdata[15:0];
      if (paddr == ccm_iv_pkg::ACCESS_ID_ADDR) id_q <= pwdata;
      if (paddr == ccm_iv_pkg::PORT_ID_ADDR) ps_q <= pwdata[19:0];
      if (paddr == ccm_iv_pkg::LEN_ADDR) len_q <= pwdata[15:0];
      if (paddr == ccm_iv_pkg::CTRL_ADDR) up_q <= pwdata[3];
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_flags; iv_valid |-> iv[127:120] == 8'h09; endproperty
  a_flags: assert property (p_flags)
    else $error("flags octet wrong");
  property p_resv; iv_valid |-> iv[119:112] == 8'h00 && iv[30:27] == 4'h0; endproperty
  a_resv: assert property (p_resv)
    else $error("reserved bits not zero");
  property p_fixed; iv_valid |-> iv[23:16] == 8'h00; endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed octet not zero");
  property p_nonce; iv_valid |-> nonce == iv[119:16]; endproperty
  a_nonce: assert property (p_nonce)
    else $error("nonce differs from octets 1 to 13");
  property p_pn; iv_load |-> iv[111:64] == pn_q; endproperty
  a_pn: assert property (p_pn)
    else $error("packet number misplaced");
  property p_ids; iv_load |-> iv[63:32] == {id_q[11:0], ps_q}; endproperty
  a_ids: assert property (p_ids)
    else $error("identity octets wrong");
  property p_dir; iv_load |-> iv[31] == up_q; endproperty
  a_dir: assert property (p_dir)
    else $error("direction bit wrong");
  property p_len; iv_load |-> iv[15:0] == len_q && len_q != 16'h0000; endproperty
  a_len: assert property (p_len)
    else $error("length octets wrong");
  property p_move; !$stable(iv) |-> iv_load && iv_valid; endproperty
  a_move: assert property (p_move)
    else $error("vector moved without a load");
  property p_pulse; iv_load |=> !iv_load; endproperty
  a_pulse: assert property (p_pulse)
    else $error("load pulse too long");
  property p_wait; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_wait: assert property (p_wait)
    else $error("apb wait state wrong");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("error without ready");
endmodule

bind ccm_iv_builder ccm_iv_builder_asserts #(
  .ACCESS_ID_W(ACCESS_ID_W),
  .CONN_W(CONN_W)
) i_chk (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .iv, .nonce, .iv_valid, .iv_load);
`default_nettype wire

// *** sim/ccm_engine_model.sv ***
// behavioural ccm engine front end that takes each new vector
`timescale 1ns/1ns
`default_nettype none

module ccm_engine_model (
  input wire logic mclk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic [ccm_iv_pkg::IV_BITS-1:0] iv, // vector offered
  input wire logic [ccm_iv_pkg::NONCE_BITS-1:0] nonce, // nonce offered
  input wire logic iv_load, // new vector strobe
  output logic [127:0] blk_q, // first block as the engine forms it
  output logic [15:0] n_blk_q // vectors taken
);
  // the engine takes flags and length from the vector but the nonce from
  // its own port, so a nonce that disagrees shows up in blk_q
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      blk_q <= '0;
      n_blk_q <= 16'h0000;
    end else if (iv_load) begin
      blk_q <= {iv[127:120], nonce, iv[15:0]};
      n_blk_q <= n_blk_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking testbench for the ccm vector builder
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, iv_valid, iv_load, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cn, ar;
  logic [3:0] pstrb;
  logic [127:0] iv, blk, last;
  logic [103:0] nonce;
  logic [47:0] pn;
  logic [19:0] ps;
  logic [15:0] n_blk, blk0, ln;
  logic [2:0] cur_lcn;
  int n_errors, compares;

  ccm_iv_builder i_dut (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .iv, .nonce, .iv_valid, .iv_load);
  ccm_engine_model i_eng (.mclk, .arst_n, .iv, .nonce, .iv_load, .blk_q(blk),
    .n_blk_q(n_blk));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [127:0] exp_iv(logic [47:0] p, logic [31:0] a,
    logic [19:0] s, logic [2:0] l, logic u, logic [15:0] n);
    return {8'h09, 8'h00, p, a[11:0], s, u, 4'h0, l, 8'h00, n};
  endfunction

  task automatic build(input logic u);
    logic [127:0] e;
    int n;
    e = exp_iv(pn, ar, ps, cur_lcn, u, ln);
    n = 0;
    apb(1'b1, ccm_iv_pkg::PN_LO_ADDR, pn[31:0]);
    apb(1'b1, ccm_iv_pkg::PN_HI_ADDR, {16'h0000, pn[47:32]});
    apb(1'b1, ccm_iv_pkg::ACCESS_ID_ADDR, ar);
    apb(1'b1, ccm_iv_pkg::PORT_ID_ADDR, {12'h000, ps});
    apb(1'b1, ccm_iv_pkg::LEN_ADDR, {16'h0000, ln});
    apb(1'b1, ccm_iv_pkg::CTRL_ADDR, {28'h000_0000, u, 3'h1});
    while (iv_load !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 40) n_errors++;
    chk(iv, e);
    chk(iv_valid, 1'b1);
    chk(nonce, e[119:16]);
    for (int w = 0; w < 4; w++) begin
      apb(1'b0, ccm_iv_pkg::IV_BASE_ADDR + 12'(4 * w), 32'h0000_0000);
      chk(rd, e[127 - 32 * w -: 32]);
    end
    chk(blk, e);
    last = e;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    arst_n = 1'b0;
    void'($urandom(22540));
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    chk(iv, '0);
    chk(iv_valid, 1'b0);
    apb(1'b0, ccm_iv_pkg::STATUS_ADDR, 32'h0000_0000);
    chk({er, rd}, '0);
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk({er, rd}, {1'b1, 32'h0000_0000});
    apb(1'b1, 12'h034, 32'hffff_ffff);
    chk(er, 1'b1);
    // build with the link closed is refused
    apb(1'b1, ccm_iv_pkg::LEN_ADDR, 32'h0000_0001);
    apb(1'b1, ccm_iv_pkg::CTRL_ADDR, 32'h0000_0001);
    repeat (8) @(posedge mclk);
    chk(n_blk, 16'h0000);
    apb(1'b0, ccm_iv_pkg::STATUS_ADDR, 32'h0000_0000);
    chk(rd[2:0], 3'h4);
    apb(1'b1, ccm_iv_pkg::STATUS_ADDR, 32'h0000_0004);
    apb(1'b0, ccm_iv_pkg::STATUS_ADDR, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // open the link; the connection number fixes the link number
    cn = $urandom;
    cur_lcn = cn[2:0];
    apb(1'b1, ccm_iv_pkg::CONN_ADDR, cn);
    apb(1'b1, ccm_iv_pkg::CTRL_ADDR, 32'h0000_0002);
    apb(1'b0, ccm_iv_pkg::STATUS_ADDR, 32'h0000_0000);
    chk(rd[6:0], {cur_lcn, 4'h8});
    // corners of the packet number, identity, port and length fields
    {pn, ar, ps, ln} = {48'hffff_ffff_ffff, 32'hffff_ffff, 20'hf_ffff, 16'hffff};
    build(1'b1);
    {pn, ar, ps, ln} = {48'h0000_0000_0000, 32'h0000_0000, 20'h0_0000, 16'h0001};
    build(1'b0);
    // random fields, each one built in both directions
    for (int i = 0; i < 6; i++) begin
      pn = {8'($urandom), 32'($urandom), 8'($urandom)}; // low byte is the sequence number
      ar = $urandom;
      ps = 20'($urandom);
      ln = 16'($urandom_range(65535, 1));
      build(1'b0);
      build(1'b1);
    end
    // a repeat open with a new connection number keeps the captured link number; a reopen after close takes the new one
    apb(1'b1, ccm_iv_pkg::CONN_ADDR, cn ^ 32'h0000_0005);
    apb(1'b1, ccm_iv_pkg::CTRL_ADDR, 32'h0000_0002);
    build(1'b0);
    apb(1'b1, ccm_iv_pkg::CTRL_ADDR, 32'h0000_0004);
    apb(1'b0, ccm_iv_pkg::STATUS_ADDR, 32'h0000_0000);
    chk({rd[3], rd[0]}, 2'h0);
    cur_lcn = cur_lcn ^ 3'h5;
    apb(1'b1, ccm_iv_pkg::CTRL_ADDR, 32'h0000_0002);
    build(1'b1);
    // zero length is refused and leaves the vector alone
    blk0 = n_blk;
    apb(1'b1, ccm_iv_pkg::LEN_ADDR, 32'h0000_0000);
    apb(1'b1, ccm_iv_pkg::CTRL_ADDR, 32'h0000_0001);
    repeat (8) @(posedge mclk);
    chk(n_blk, blk0);
    chk(iv, last);
    chk(iv_valid, 1'b0);
    apb(1'b0, ccm_iv_pkg::STATUS_ADDR, 32'h0000_0000);
    chk(rd[2:1], 2'h1);
    // vector words are read-only
    apb(1'b1, ccm_iv_pkg::IV_BASE_ADDR, 32'h0000_0000);
    apb(1'b0, ccm_iv_pkg::IV_BASE_ADDR, 32'h0000_0000);
    chk({er, rd}, {1'b0, last[127:96]});
    wrap_up();
  end

  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
